// [hdl/excl_ctrl.sv]
// Exclusive-control arbiter between the RF reader and a serial host.
// Assumes front ends deliver one-cycle event pulses on sys_clk, and that
// the carrier detect pin is asynchronous and must be synchronised here.
// Function
// RULE1 - Lock out other commands during active mode
// RULE2 - Lockout from command start to response end
// RULE3 - Tunnel lockout spans reader command to reply
// RULE4 - Faulty host command during lockout gets 0x06
// RULE5 - Unimplemented host command gets BUSY
// RULE6 - RF active: host gets BUSY or 0x06
// RULE7 - Serial active: reader commands get no reply
// RULE8 - Tunnel poll/reply pending: host gets silence
// RULE9 - UART pre-IRQ host command: BUSY, IRQ after wait
// RULE10 - UART post-IRQ: BUSY unless host poll
// RULE11 - Clocked pre-IRQ: BUSY, IRQ reissued after 1us
// RULE12 - Clocked post-IRQ: BUSY unless host poll
// RULE13 - Route select 1: IRQ sends 0xFE on TX
// RULE14 - Host pads unknown length to 256 bytes
// RULE15 - Clocked, no poll wait: only count retries
// RULE16 - First relay state: repeat IRQ on UART only
// RULE17 - Carrier loss returns to idle
`timescale 1ns/1ps
`default_nettype none
module excl_ctrl
    import excl_ctrl_pkg::*;
#(
    parameter int RETRY_W = 8
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_b,
    input  wire logic                       uartSel,
    input  wire logic                       irq_route_select,
    input  wire logic [excl_ctrl_pkg::WAIT_W-1:0] async_wait_time,
    input  wire logic                       poll_wait_time,
    input  wire logic                       carrierPin,
    input  wire excl_ctrl_pkg::host_cmd_type hostCmd,
    input  wire logic                       hostRspEnd,
    input  wire excl_ctrl_pkg::rf_cmd_type  rfCmd,
    input  wire logic                       tunnelRxDone,
    input  wire logic                       txIdle,
    output excl_ctrl_pkg::reply_type        hostReply,
    output logic                            hostAccept,
    output logic                            rfAccept,
    output logic                            irqPin,
    output logic                            irqTxStart,
    output logic [7:0]                      irqTxCode,
    output logic [RETRY_W-1:0]              poll_retry_count,
    output logic                            lockActive
);
    import excl_ctrl_pkg::*;

    // Reissue bound for checking: timer expiry, output register and one spare cycle.
    localparam int REISSUE_LIM = REISSUE_CYCLES + 3;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RF,
        S_SERIAL,
        S_TUN_RX,
        S_RELAY_FIRST,
        S_TUN_HOST,
        S_TUN_RSP
    } state_type;

    state_type          state_q;
    logic               carMeta_q;
    logic               carSync_q;
    logic               busyReplied_q;
    reply_type          reply_q;
    logic               irqPin_q;
    logic               irqTx_q;
    logic [RETRY_W-1:0] retry_q;
    logic               reissueLoad;
    logic               reissueExp;
    logic               asyncLoad;
    logic               asyncExp;
    logic               irqFire;
    logic               cancelTimers;
    logic [WAIT_W-1:0]  reissueCount;

    // Reply code for a locked-out host command; a fault outranks BUSY.
    function automatic reply_type lockReply(input logic bad);
        return bad ? REPLY_ERROR : REPLY_BUSY; // [RULE4] [RULE5]
    endfunction

    // Carrier detect arrives from the analog front end, so two flops first.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            carMeta_q <= 1'b0;
            carSync_q <= 1'b0;
        end else begin
            carMeta_q <= carrierPin;
            carSync_q <= carMeta_q;
        end
    end

    assign cancelTimers = !carSync_q;
    assign reissueCount = WAIT_W'(REISSUE_CYCLES);

    // UART path: interrupt waits for the configured asynchronous wait.
    wait_timer #(.W(WAIT_W)) asyncTimer (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .load    (asyncLoad),
        .cancel  (cancelTimers),
        .count   (async_wait_time),
        .expired (asyncExp),
        .running ()
    );

    // Clocked path: interrupt is reissued shortly after the BUSY reply.
    wait_timer #(.W(WAIT_W)) reissueTimer (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .load    (reissueLoad),
        .cancel  (cancelTimers),
        .count   (reissueCount),
        .expired (reissueExp),
        .running ()
    );

    // A host command that lands before the interrupt, or on UART in the first relay state, arms the right timer.
    always_comb begin
        asyncLoad   = 1'b0;
        reissueLoad = 1'b0;
        if (state_q == S_TUN_RX && busyReplied_q && hostRspEnd) begin
            asyncLoad   = uartSel;  // [RULE9]
            reissueLoad = !uartSel; // [RULE11]
        end
        if (state_q == S_RELAY_FIRST && uartSel && hostRspEnd) begin
            asyncLoad = 1'b1; // [RULE16]
        end
    end

    // Interrupt raised at tunnel reception, after a pre-IRQ BUSY, or after a reply on UART in the first relay state. On the
    // clocked link with no poll wait pending, the interrupt is suppressed.
    always_comb begin
        irqFire = 1'b0;
        if (state_q == S_TUN_RX && tunnelRxDone && !busyReplied_q) begin
            irqFire = uartSel || poll_wait_time; // [RULE15]
        end
        if (asyncExp) begin
            irqFire = 1'b1; // [RULE9] [RULE16]
        end
        if (reissueExp && poll_wait_time) begin
            irqFire = 1'b1; // [RULE11] [RULE15]
        end
    end

    // Operation mode tracker; lock held from command start to response end.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q <= S_IDLE;
        end else if (!carSync_q) begin
            state_q <= S_IDLE; // [RULE17]
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (rfCmd.start && rfCmd.isTunnel) begin
                        state_q <= S_TUN_RX; // [RULE3]
                    end else if (rfCmd.start) begin
                        state_q <= S_RF; // [RULE2]
                    end else if (hostCmd.start) begin
                        state_q <= S_SERIAL; // [RULE2]
                    end
                end
                S_RF: begin
                    if (rfCmd.rspEnd) begin
                        state_q <= S_IDLE; // [RULE2]
                    end
                end
                S_SERIAL: begin
                    if (hostRspEnd) begin
                        state_q <= S_IDLE; // [RULE2]
                    end
                end
                S_TUN_RX: begin
                    if (tunnelRxDone) begin
                        state_q <= S_RELAY_FIRST;
                    end
                end
                S_RELAY_FIRST: begin
                    if (hostCmd.done && !hostCmd.badCheck && hostCmd.isReply) begin
                        state_q <= S_TUN_RSP;
                    end else if (hostCmd.done && !hostCmd.badCheck && hostCmd.isPoll) begin
                        state_q <= S_TUN_HOST;
                    end
                end
                S_TUN_HOST: begin
                    if (hostRspEnd) begin
                        state_q <= S_RELAY_FIRST;
                    end
                end
                S_TUN_RSP: begin
                    if (rfCmd.rspEnd) begin
                        state_q <= S_IDLE; // [RULE3]
                    end
                end
            endcase
        end
    end

    // Remember a BUSY given before the tunnel interrupt went out.
    always_ff @(posedge sys_clk) begin
        if (!rst_b || state_q != S_TUN_RX) begin
            busyReplied_q <= 1'b0;
        end else if (hostCmd.done) begin
            busyReplied_q <= 1'b1;
        end
    end

    // Reply to host commands while locked; silence where the host's own
    // transaction already owns the link.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reply_q <= REPLY_NONE;
        end else if (hostCmd.done) begin
            unique case (state_q)
                S_RF, S_TUN_RX: reply_q <= lockReply(hostCmd.badCheck); // [RULE6] [RULE9] [RULE11]
                S_RELAY_FIRST: begin
                    if (hostCmd.isPoll && !hostCmd.badCheck) begin
                        reply_q <= REPLY_NONE;
                    end else begin
                        reply_q <= lockReply(hostCmd.badCheck); // [RULE10] [RULE12]
                    end
                end
                default: reply_q <= REPLY_NONE; // [RULE8]
            endcase
        end else begin
            reply_q <= REPLY_NONE;
        end
    end

    // Interrupt output: a pin level, or the 0xFE code on the transmitter.
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !carSync_q) begin
            irqPin_q <= 1'b0;
            irqTx_q  <= 1'b0;
        end else begin
            irqTx_q <= irqFire && (irq_route_select == ROUTE_TX) && txIdle; // [RULE13]
            if (irqFire && irq_route_select != ROUTE_TX) begin
                irqPin_q <= 1'b1;
            end else if (hostCmd.start) begin
                irqPin_q <= 1'b0;
            end
        end
    end

    // Retry counter counts clocked tunnel receptions with no poll wait pending; suppressed reissues are not counted.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            retry_q <= '0;
        end else if (state_q == S_TUN_RX && tunnelRxDone && !uartSel && !poll_wait_time) begin
            retry_q <= retry_q + 1'b1; // [RULE15]
        end
    end

    // Acceptance only in idle; everything else is locked out.
    assign hostAccept       = hostCmd.start && state_q == S_IDLE && !rfCmd.start; // [RULE1]
    assign rfAccept         = rfCmd.start && state_q == S_IDLE; // [RULE1] [RULE7]
    assign lockActive       = state_q != S_IDLE;
    assign hostReply        = reply_q;
    assign irqPin           = irqPin_q;
    assign irqTxStart       = irqTx_q;
    assign irqTxCode        = CODE_IRQ;
    assign poll_retry_count = retry_q;

    // Reader commands never reach the core during a serial transaction.
    a_serial_blocks_rf: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_q == S_SERIAL |-> !rfAccept) // [RULE7]
        else $error("reader accepted during serial lock");
    a_fault_gets_error: assert property (@(posedge sys_clk) disable iff (!rst_b)
        hostCmd.done && hostCmd.badCheck && state_q == S_RF && carSync_q
        |=> hostReply == REPLY_ERROR) // [RULE4]
        else $error("fault not answered with error code");
    a_rf_gives_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        hostCmd.done && !hostCmd.badCheck && state_q == S_RF |=> hostReply == REPLY_BUSY) // [RULE6]
        else $error("host not busied during RF lock");
    a_poll_silent: assert property (@(posedge sys_clk) disable iff (!rst_b)
        hostCmd.done && (state_q == S_TUN_HOST || state_q == S_TUN_RSP)
        |=> hostReply == REPLY_NONE) // [RULE8]
        else $error("reply given during tunnel host exchange");
    a_post_irq_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        hostCmd.done && !hostCmd.isPoll && !hostCmd.badCheck && state_q == S_RELAY_FIRST
        |=> hostReply == REPLY_BUSY) // [RULE10] [RULE12]
        else $error("non-poll command not busied after interrupt");
    a_carrier_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !carSync_q |=> state_q == S_IDLE) // [RULE17]
        else $error("carrier loss did not return to idle");
    a_irq_code_tx: assert property (@(posedge sys_clk) disable iff (!rst_b)
        irqTxStart |-> $past(irq_route_select) == ROUTE_TX && irqTxCode == CODE_IRQ) // [RULE13]
        else $error("interrupt code sent without route select");
    a_clocked_reissue: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reissueLoad && poll_wait_time && carSync_q && txIdle
        |-> ##[1:REISSUE_LIM] (irqPin || irqTxStart || !txIdle || !carSync_q || !poll_wait_time)) // [RULE11]
        else $error("interrupt not reissued after busy reply");
    a_lock_held: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_q == S_RF && !rfCmd.rspEnd && carSync_q |=> lockActive) // [RULE2] [RULE1]
        else $error("lock dropped before response end");

    c_tunnel_seen: cover property (@(posedge sys_clk) disable iff (!rst_b)
        state_q == S_TUN_RX ##1 state_q == S_RELAY_FIRST);
    c_busy_pre_irq: cover property (@(posedge sys_clk) disable iff (!rst_b)
        asyncExp);
    c_reissue: cover property (@(posedge sys_clk) disable iff (!rst_b)
        reissueExp);
    c_retry: cover property (@(posedge sys_clk) disable iff (!rst_b)
        retry_q != '0);
endmodule
`default_nettype wire

// [hdl/excl_ctrl_pkg.sv]
// Package for the exclusive-control arbiter: reply codes, timing, command events.
// Assumes a 40 MHz core clock shared by the RF and serial front ends.
package excl_ctrl_pkg;

    localparam int          CLK_MHZ         = 40;
    localparam int          REISSUE_NS      = 1000;
    // Least time, rounded up to whole cycles.
    localparam int          REISSUE_CYCLES  = (REISSUE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  CODE_ERROR      = 8'h06;
    localparam logic [7:0]  CODE_IRQ        = 8'hFE;
    localparam logic        ROUTE_TX        = 1'b1;
    localparam int          WAIT_W          = 16;

    typedef enum logic [1:0] {
        REPLY_NONE,
        REPLY_BUSY,
        REPLY_ERROR
    } reply_type;

    // Command event from the host serial front end.
    typedef struct packed {
        logic start;     // First byte of a host command seen.
        logic done;      // Command reception finished.
        logic isPoll;    // Command is the host poll command.
        logic isReply;   // Command is the host reply command.
        logic badCheck;  // Parity or checksum fault.
    } host_cmd_type;

    // Command event from the RF front end.
    typedef struct packed {
        logic start;     // Reader command begins.
        logic isTunnel;  // Command is a tunnel command.
        logic rspEnd;    // Device response to the reader finished.
    } rf_cmd_type;

endpackage

// [hdl/wait_timer.sv]
// Down counter that pulses once a loaded wait has elapsed.
// Assumes load and the count value come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module wait_timer #(
    parameter int W = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         load,
    input  wire logic         cancel,
    input  wire logic [W-1:0] count,
    output logic              expired,
    output logic              running
);
    logic [W-1:0] cnt_q;
    logic         run_q;

    // Counter reloads on load; a count of zero expires after one cycle.
    always_ff @(posedge sys_clk) begin
        if (!rst_b || cancel) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (load) begin
            cnt_q <= count;
            run_q <= 1'b1;
        end else if (run_q) begin
            if (cnt_q == '0) begin
                run_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    assign expired = run_q && (cnt_q == '0) && !load && !cancel;
    assign running = run_q;
endmodule
`default_nettype wire

// [tb/excl_ctrl_tb.sv]
// Self-checking bench for the exclusive-control arbiter.
// Assumes the host model drives the host side; the bench drives the reader side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %0h expected %0h", $time, a, e); end end
module excl_ctrl_tb;
    import excl_ctrl_pkg::*;
    localparam int AW = 20;
    logic         sys_clk, rst_b, uartSel, irq_route_select;
    logic         poll_wait_time, carrierPin, tunnelRxDone, hostRspEnd, txIdle;
    logic [15:0]  async_wait_time;
    host_cmd_type hostCmd;
    rf_cmd_type   rfCmd;
    reply_type    hostReply, r;
    logic         hostAccept, rfAccept, irqPin, irqTxStart, lockActive, a;
    logic [7:0]   irqTxCode, poll_retry_count;
    int           err_total, n_checks, n;
    int           nTaken = 0;

    excl_ctrl uut (.sys_clk(sys_clk), .rst_b(rst_b), .uartSel(uartSel),
        .irq_route_select(irq_route_select), .async_wait_time(async_wait_time),
        .poll_wait_time(poll_wait_time), .carrierPin(carrierPin), .hostCmd(hostCmd),
        .hostRspEnd(hostRspEnd), .rfCmd(rfCmd), .tunnelRxDone(tunnelRxDone),
        .txIdle(txIdle), .hostReply(hostReply), .hostAccept(hostAccept),
        .rfAccept(rfAccept), .irqPin(irqPin), .irqTxStart(irqTxStart),
        .irqTxCode(irqTxCode), .poll_retry_count(poll_retry_count),
        .lockActive(lockActive));
    host_model host (.sys_clk(sys_clk), .uartSel(uartSel), .hostReply(hostReply),
        .hostCmd(hostCmd), .hostRspEnd(hostRspEnd), .txIdle(txIdle));

    // Counts host starts taken by the arbiter; only an idle arbiter may take one.
    always @(posedge sys_clk) begin
        if (hostAccept === 1'b1) nTaken <= nTaken + 1;
    end

    // A 40 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Drives land 2 ns after the edge so the design samples settled values.
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask

    // Reset clears the carrier synchroniser; three cycles after release let it fill.
    task automatic do_reset();
        rst_b = 1'b0;
        tick(10);
        rst_b = 1'b1;
        tick(3);
    endtask

    // Reader command start; the accept flag is combinational, so it is read in the same cycle.
    task automatic rf_go(input logic tun, output logic acc);
        tick(1);
        rfCmd = '{1'b1, tun, 1'b0};
        #1 acc = rfAccept;
        tick(1);
        rfCmd = '0;
    endtask

    task automatic rf_end();
        tick(1);
        rfCmd.rspEnd = 1'b1;
        tick(1);
        rfCmd = '0;
    endtask

    task automatic rx_done();
        tick(1);
        tunnelRxDone = 1'b1;
        tick(1);
        tunnelRxDone = 1'b0;
    endtask

    // Counts cycles until an interrupt shows, giving up after 100 so silence is measurable.
    task automatic wait_irq(output int k);
        k = 0;
        while (!(irqPin === 1'b1 || irqTxStart === 1'b1) && k < 100) begin
            tick(1);
            k++;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // A hang is cut off at 300 us, 12000 cycles, about twelve times the thousand or so cycles the sequence needs.
    initial begin
        #300us;
        err_total++;
        wrap_up();
    end

    initial begin
        err_total = 0; n_checks = 0;
        rst_b = 1'b0; uartSel = 1'b1; irq_route_select = 1'b0; poll_wait_time = 1'b1;
        carrierPin = 1'b1; tunnelRxDone = 1'b0; rfCmd = '0; async_wait_time = 16'(AW);
        do_reset();
        `CHK(lockActive, 1'b0)
        `CHK(irqTxCode, CODE_IRQ)
        // Reader transaction: host sees BUSY or the error code, reader restarts refused.
        rf_go(1'b0, a);
        `CHK(lockActive, 1'b1)
        host.send(1'b0, 1'b0, 1'b0, r);
        `CHK(r, REPLY_BUSY)
        host.send(1'b0, 1'b0, 1'b1, r);
        `CHK(r, REPLY_ERROR)
        `CHK(nTaken, 0)
        rf_go(1'b1, a);
        `CHK(a, 1'b0)
        rf_end();
        `CHK(lockActive, 1'b0)
        // Serial transaction: reader commands of both kinds go unanswered.
        host.send(1'b0, 1'b0, 1'b0, r);
        `CHK(lockActive, 1'b1)
        `CHK(nTaken, 1)
        rf_go(1'b1, a);
        `CHK(a, 1'b0)
        rf_go(1'b0, a);
        `CHK(a, 1'b0)
        host.rsp_end();
        `CHK(lockActive, 1'b0)
        // UART tunnel with the interrupt already out, then the full relay order.
        rf_go(1'b1, a);
        rx_done();
        wait_irq(n);
        `CHK(n <= 1, 1'b1)
        `CHK(a, 1'b1)
        host.send(1'b0, 1'b0, 1'b0, r);
        `CHK(r, REPLY_BUSY)
        host.rsp_end();
        wait_irq(n);
        `CHK(n >= AW - 2 && n <= AW + 3, 1'b1)
        host.send(1'b1, 1'b0, 1'b0, r);
        `CHK(r, REPLY_NONE)
        host.send(1'b0, 1'b0, 1'b0, r);
        `CHK(r, REPLY_NONE)
        host.rsp_end();
        host.send(1'b0, 1'b1, 1'b0, r);
        `CHK(r, REPLY_BUSY)
        host.send(1'b0, 1'b0, 1'b0, r);
        `CHK(r, REPLY_NONE)
        `CHK(lockActive, 1'b1)
        rf_end();
        `CHK(lockActive, 1'b0)
        // UART tunnel with a host command before the interrupt, then carrier loss.
        rf_go(1'b1, a);
        host.send(1'b0, 1'b0, 1'b0, r);
        `CHK(r, REPLY_BUSY)
        host.rsp_end();
        rx_done();
        wait_irq(n);
        `CHK(n >= AW - 3 && n <= AW + 3, 1'b1)
        carrierPin = 1'b0;
        tick(4);
        `CHK(lockActive, 1'b0)
        carrierPin = 1'b1;
        // Clocked link, interrupt routed as a code on the transmit line.
        uartSel = 1'b0;
        irq_route_select = ROUTE_TX;
        do_reset();
        rf_go(1'b1, a);
        host.send(1'b0, 1'b0, 1'b0, r);
        `CHK(r, REPLY_BUSY)
        host.rsp_end();
        rx_done();
        wait_irq(n);
        `CHK(n >= REISSUE_CYCLES - 3 && n <= REISSUE_CYCLES + 3, 1'b1)
        `CHK(irqTxStart, 1'b1)
        `CHK(irqPin, 1'b0)
        host.send(1'b0, 1'b0, 1'b0, r);
        `CHK(r, REPLY_BUSY)
        host.rsp_end();
        wait_irq(n);
        `CHK(n, 100)
        host.send(1'b1, 1'b0, 1'b0, r);
        `CHK(r, REPLY_NONE)
        host.send(1'b0, 1'b1, 1'b0, r);
        `CHK(r, REPLY_NONE)
        host.rsp_end();
        host.send(1'b0, 1'b1, 1'b0, r);
        `CHK(r, REPLY_BUSY)
        `CHK(lockActive, 1'b1)
        rf_end();
        `CHK(lockActive, 1'b0)
        // Clocked link with no poll wait pending: count a retry, raise nothing.
        poll_wait_time = 1'b0;
        do_reset();
        rf_go(1'b1, a);
        rx_done();
        wait_irq(n);
        `CHK(n, 100)
        `CHK(poll_retry_count, 8'h01)
        carrierPin = 1'b0;
        tick(4);
        `CHK(lockActive, 1'b0)
        wrap_up();
    end
endmodule
`default_nettype wire

// [tb/host_model.sv]
// Behavioural serial host that sits on the far side of the arbiter.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import excl_ctrl_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      uartSel,
    input  wire excl_ctrl_pkg::reply_type  hostReply,
    output excl_ctrl_pkg::host_cmd_type    hostCmd,
    output logic                           hostRspEnd,
    output logic                           txIdle
);
    import excl_ctrl_pkg::*;

    // The line starts quiet with the transmitter free.
    initial begin
        hostCmd    = '0;
        hostRspEnd = 1'b0;
        txIdle     = 1'b1;
    end

    // One host command, start pulse then done pulse; the reply is taken one edge later.
    task automatic send(input logic poll, input logic rpl, input logic bad,
                        output reply_type r);
        @(posedge sys_clk);
        #2 hostCmd.start = 1'b1;
        @(posedge sys_clk);
        #2 hostCmd.start = 1'b0;
        // With no known length the clocked link needs the full 256-byte frame.
        if (!uartSel && rpl) repeat (256) @(posedge sys_clk);
        else repeat (2) @(posedge sys_clk);
        #2 hostCmd = '{1'b0, 1'b1, poll, rpl, bad};
        @(posedge sys_clk);
        // Qualifiers are only meaningful with done, so they are scrambled afterwards.
        #2 hostCmd = '{1'b0, 1'b0, ~poll, ~rpl, ~bad};
        r = hostReply;
    endtask

    // Marks the end of the device's reply to the host.
    task automatic rsp_end();
        @(posedge sys_clk);
        #2 hostRspEnd = 1'b1;
        @(posedge sys_clk);
        #2 hostRspEnd = 1'b0;
    endtask
endmodule
`default_nettype wire
